// ===== tb/tb_variable_latency_io_slave_port.sv
// Bench joining host and slave port, checking read-back data
`timescale 1ns/100ps
module tb_variable_latency_io_slave_port;
	import vlp_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0, req_write = 1'b0, req_burst = 1'b0;
	logic [1:0] req_select = 2'h0;
	logic [VLP_ADDR_W-1:0] req_addr = '0;
	logic [3:0] req_lanes = 4'hF;
	logic [VLP_DATA_W-1:0] req_wdata = '0;
	logic req_ready, rsp_valid, hold_active_high;
	logic [VLP_DATA_W-1:0] rsp_rdata;
	logic strap = 1'b1;
	logic big_endian = 1'b0;
	int errors = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'h0000D611;
	logic [16:0] exp_q[$];
	logic [16:0] x;
	logic [15:0] mem[8];
	vlp_bus_if bus_if();
	vlp_host i_vlp_host(.clk(clk), .rst(rst), .bus(bus_if.host), .req_valid(req_valid),
		.req_write(req_write), .req_burst(req_burst), .req_select(req_select),
		.req_addr(req_addr), .req_lanes(req_lanes), .req_wdata(req_wdata),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
	vlp_device i_vlp_device(.clk(clk), .rst(rst), .bus(bus_if.device),
		.wait_polarity_strap(strap), .big_endian(big_endian),
		.hold_active_high(hold_active_high));
	vlp_bus_sva i_vlp_bus_sva(.clk(clk), .rst(rst), .host_select_low(bus_if.host_select_low),
		.lane_strobe_low(bus_if.lane_strobe_low), .read_strobe_low(bus_if.read_strobe_low),
		.write_strobe_low(bus_if.write_strobe_low), .host_doe_n(bus_if.host_doe_n),
		.dev_dout(bus_if.dev_dout), .dev_doe_n(bus_if.dev_doe_n), .ready(bus_if.ready));
	initial begin
		forever #10 clk = ~clk;
	end
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic final_report();
		$display("compares=%0d mismatches=%0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	// Expectation noted first; request held until the host takes it
	task automatic access(input logic wr, input logic bu, input logic [2:0] idx,
		input logic [3:0] ln, input logic [15:0] wd);
		logic [15:0] e;
		int n;
		e = mem[idx];
		if (wr && !ln[0]) e[7:0] = wd[7:0];
		if (wr && !ln[1]) e[15:8] = wd[15:8];
		if (wr) mem[idx] = e;
		exp_q.push_back({!wr, e});
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= wr;
		req_burst <= bu;
		if (!bu) req_select <= 2'(rnd() % 3);
		req_addr <= {22'h000000, idx, 1'b0};
		req_lanes <= ln;
		req_wdata <= {16'h0000, wd};
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 300);
		if (n >= 300) begin
			errors++;
			final_report();
		end
		@(posedge clk);
		req_valid <= 1'b0;
	endtask : access
	// Responses arrive in request order, so the oldest note matches
	always @(negedge clk) begin
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				errors++;
			end else begin
				x = exp_q.pop_front();
				if (x[16]) check(rsp_rdata[15:0], x[15:0]);
			end
		end
	end
	initial begin
		#(20 * 20000);
		errors++;
		final_report();
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		check({15'h0000, hold_active_high}, 16'h0001);
		for (int p = 0; p < 2; p++) begin
			big_endian <= p[0];
			for (int i = 0; i < 8; i++) access(1'b1, 1'b0, 3'(i), 4'hC, 16'(rnd()));
			if (p == 0) begin
				for (int i = 0; i < 4; i++) access(1'b1, 1'b0, 3'(i), i[0] ? 4'hD : 4'hE, 16'(rnd()));
			end
			for (int i = 0; i < 8; i++) access(1'b0, i != 0, 3'(i), 4'hC, 16'h0000);
			for (int n = 0; n < 400 && exp_q.size() != 0; n++) @(posedge clk);
			$display("pass %0d done", p);
		end
		// Second reset with the strap low: polarity must follow it
		strap <= 1'b0;
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		check({15'h0000, hold_active_high}, 16'h0000);
		$display("strap test done");
		final_report();
	end
endmodule : tb_variable_latency_io_slave_port

// ===== tb/vlp_bus_sva.sv
// Concurrent checks on the bus between host and slave port
`timescale 1ns/100ps
module vlp_bus_sva
	import vlp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [VLP_SEL_W-1:0] host_select_low,
	input wire logic [VLP_LANES-1:0] lane_strobe_low,
	input wire logic read_strobe_low,
	input wire logic write_strobe_low,
	input wire logic host_doe_n,
	input wire logic [VLP_DATA_W-1:0] dev_dout,
	input wire logic dev_doe_n,
	input wire logic ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic sel_act;
	logic cmd_act;
	logic [3:0] rdy_cnt_q;
	assign sel_act = host_select_low != VLP_SEL_IDLE;
	assign cmd_act = !read_strobe_low || !write_strobe_low;
	// Run of ready-high cycles under a strobe; saturates so it never wraps
	always_ff @(posedge clk) begin
		if (rst || !cmd_act || !ready) begin
			rdy_cnt_q <= 4'h0;
		end else if (rdy_cnt_q != 4'hF) begin
			rdy_cnt_q <= rdy_cnt_q + 4'h1;
		end
	end
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	property p_no_fight;
		!dev_doe_n |-> host_doe_n;
	endproperty
	a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
	property p_drive_selected;
		!dev_doe_n |-> sel_act;
	endproperty
	a_drive_selected: assert property (p_drive_selected) else $error("data driven unselected");
	property p_one_cmd;
		read_strobe_low || write_strobe_low;
	endproperty
	a_one_cmd: assert property (p_one_cmd) else $error("read and write strobes both low");
	property p_sel_to_cmd;
		$rose(sel_act) |-> !cmd_act [*4] ##1 cmd_act;
	endproperty
	a_sel_to_cmd: assert property (p_sel_to_cmd) else $error("strobe not 4 ticks after select");
	property p_cmd_width;
		$rose(cmd_act) |-> cmd_act [*6];
	endproperty
	a_cmd_width: assert property (p_cmd_width) else $error("strobe too short");
	property p_precharge;
		$fell(cmd_act) |-> !cmd_act [*2];
	endproperty
	a_precharge: assert property (p_precharge) else $error("precharge too short");
	property p_sel_hold;
		$fell(cmd_act) |-> (sel_act && lane_strobe_low != VLP_LANE_IDLE) [*2];
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("select dropped early");
	property p_three_samples;
		$fell(cmd_act) |-> rdy_cnt_q >= 4'h3;
	endproperty
	a_three_samples: assert property (p_three_samples) else $error("ended without 3 ready");
	property p_stretch;
		$rose(cmd_act) |-> ##[1:4] !ready ##[1:40] ready;
	endproperty
	a_stretch: assert property (p_stretch) else $error("ready not held off then given");
	property p_read_hold;
		$rose(read_strobe_low) |-> $past(dev_doe_n) == 1'b0 && $past(dev_doe_n, 2) == 1'b0
			&& $past(dev_dout) == $past(dev_dout, 2);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("read data not held");
	c_read: cover property ($rose(read_strobe_low));
	c_write: cover property ($rose(write_strobe_low));
	c_burst: cover property (sel_act && $rose(cmd_act) && $past(sel_act, 6));
endmodule : vlp_bus_sva

// ===== verilog/vlp_bus_if.sv
// Pin-level carrier between the host controller and the slave port
`timescale 1ns/100ps
interface vlp_bus_if;
	import vlp_pkg::*;
	logic [VLP_ADDR_W-1:0] addr;
	logic [VLP_SEL_W-1:0] host_select_low;
	logic [VLP_LANES-1:0] lane_strobe_low;
	logic read_strobe_low;
	logic write_strobe_low;
	logic [VLP_DATA_W-1:0] host_dout;
	logic host_doe_n;
	logic [VLP_DATA_W-1:0] dev_dout;
	logic dev_doe_n;
	logic ready;
	// ---------------------------------------------------------------
	// Resolved data wire
	// ---------------------------------------------------------------
	// No floating value is modelled: an undriven bus reads as zeros
	wire [VLP_DATA_W-1:0] data = !dev_doe_n ? dev_dout : (!host_doe_n ? host_dout : '0);
	modport host (output addr, output host_select_low, output lane_strobe_low,
		output read_strobe_low, output write_strobe_low, output host_dout,
		output host_doe_n, input data, input ready);
	modport device (input addr, input host_select_low, input lane_strobe_low,
		input read_strobe_low, input write_strobe_low, input data,
		output dev_dout, output dev_doe_n, output ready);
endinterface : vlp_bus_if

// ===== verilog/vlp_device.sv
// Device end: slave port that stretches host cycles with its ready output
`timescale 1ns/100ps
// Operation
// - Stretched devices only on selects three to five; the code stretches on selects zero to two, the only ones it has
// - Host has 26-bit address, 32-bit data
// - Six selects, each decoding 64M bytes; the code has three selects (VLP_SEL_W = 3)
// - Each low lane strobe picks one byte
// - Lane strobes low give transfer width
// - Address plus low select starts cycle
// - Read strobe low reads; else write strobe
// - Device stretches access by holding ready
// - Read strobe comes two cycles after select
// - Strobe width first_access_delay+1; early ready sampling
// - Three consecutive half-cycle ready samples proceed
// - Read data held until host capture
// - Strobe drops next rising edge after capture
// - Strobe precharge is command_precharge_count+1 cycles
// - Select and lanes held one cycle after
// - Each strobe in a burst is separate
// - Each select set for 16 or 32
// - Host byte order matches device order
// - Hold-off asserted until data ready/accepted
// - Upper lane strobe and A0 steer bytes; the code steers on the low lane strobe and A0
// - Strap at reset sets hold-off polarity; the code only reports it on hold_active_high, ready stays active-high
module vlp_device
	import vlp_pkg::*;
#(
	parameter int LATENCY = VLP_DEVICE_LATENCY,
	parameter int MEM_WORDS = 256
) (
	input wire logic clk,
	input wire logic rst,
	vlp_bus_if.device bus,
	input wire logic wait_polarity_strap,
	input wire logic big_endian,
	output logic hold_active_high
);
	localparam int MEM_AW = $clog2(MEM_WORDS);
	localparam int LAT_W = 8;
	vlp_dev_e state_q;
	logic [LAT_W-1:0] lat_q;
	logic pol_q;
	logic strap_taken_q;
	logic [15:0] mem_q [MEM_WORDS];
	logic [MEM_AW-1:0] idx;
	logic selected;
	logic strobe;
	logic [15:0] wr_half;
	logic [15:0] rd_half;
	logic busy;
	logic finish;
	logic is_read;
	logic is_write;
	logic [1:0] lane_we;
	logic [15:0] lane_wbyte;
	// ---------------------------------------------------------------
	// Lane decode
	// ---------------------------------------------------------------
	// A lone low-lane strobe with A0 set lands in the upper byte
	function automatic logic [1:0] lane_write_mask(input logic [3:0] lanes_low, input logic a0);
		logic lo;
		logic hi;
		lo = !lanes_low[0] && !a0;
		hi = !lanes_low[1] || (a0 && !lanes_low[0]);
		lane_write_mask = {hi, lo};
	endfunction : lane_write_mask
	// With A0 set only the upper byte is returned, moved to the low lane
	function automatic logic [15:0] read_steer(input logic [15:0] word, input logic a0);
		read_steer = a0 ? {8'h00, word[15:8]} : word;
	endfunction : read_steer
	// ---------------------------------------------------------------
	// Select and command decode
	// ---------------------------------------------------------------
	// Limitation: only the low 16 data lines are served; lanes 2 and 3
	// are accepted but ignored, so a 32-bit host must set that select
	// to a 16-bit path.
	assign selected = bus.host_select_low != VLP_SEL_IDLE;
	assign strobe = selected && (!bus.read_strobe_low || !bus.write_strobe_low);
	assign idx = bus.addr[MEM_AW:1];
	// The last busy cycle is the one moment buffer and pins both act on
	assign finish = state_q == VLP_D_BUSY && lat_q == LAT_W'(LATENCY - 1);
	assign is_read = strobe && !bus.read_strobe_low;
	assign is_write = strobe && bus.read_strobe_low && !bus.write_strobe_low;
	assign lane_we = lane_write_mask(bus.lane_strobe_low, bus.addr[0]);
	assign lane_wbyte = {bus.addr[0] ? wr_half[7:0] : wr_half[15:8], wr_half[7:0]};
	// ---------------------------------------------------------------
	// Byte steering on the 16-bit port
	// ---------------------------------------------------------------
	always_comb begin
		wr_half = big_endian ? {bus.data[7:0], bus.data[15:8]} : bus.data[15:0];
		rd_half = big_endian ? {mem_q[idx][7:0], mem_q[idx][15:8]} : mem_q[idx];
	end
	// ---------------------------------------------------------------
	// Strap capture after reset release
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			strap_taken_q <= 1'b0;
		end else begin
			strap_taken_q <= 1'b1;
		end
	end
	// Sampled once, on the first edge after release, then frozen so a
	// strap pin that is reused later cannot flip the polarity mid-run
	always_ff @(posedge clk) begin
		if (rst) begin
			pol_q <= VLP_STRAP_RESET;
		end else if (!strap_taken_q) begin
			pol_q <= wait_polarity_strap;
		end
	end
	// ---------------------------------------------------------------
	// Access sequencer, one access per strobe assertion
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= VLP_D_IDLE;
			lat_q <= '0;
		end else begin
			case (state_q)
				VLP_D_IDLE: begin
					if (strobe) begin
						lat_q <= '0;
						state_q <= VLP_D_BUSY;
					end
				end
				VLP_D_BUSY: begin
					lat_q <= lat_q + 1'b1;
					if (lat_q == LAT_W'(LATENCY - 1)) begin
						state_q <= VLP_D_DONE;
					end
				end
				VLP_D_DONE: begin
					if (!strobe) begin
						state_q <= VLP_D_IDLE;
					end
				end
				default: begin
					state_q <= VLP_D_IDLE;
				end
			endcase
		end
	end
	// ---------------------------------------------------------------
	// Write into the buffer once the access completes
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst && finish && is_write) begin
			// One byte per pass keeps byte and word writes on the same path
			for (int g = 0; g < 2; g++) begin
				if (lane_we[g]) begin
					mem_q[idx][8*g +: 8] <= lane_wbyte[8*g +: 8];
				end
			end
		end
	end
	// ---------------------------------------------------------------
	// Pin drivers
	// ---------------------------------------------------------------
	assign busy = strobe && state_q != VLP_D_DONE;
	// ---------------------------------------------------------------
	// Ready
	// ---------------------------------------------------------------
	// High means go ahead; the strap only sets the reported polarity.
	// Registered, so ready drops one edge after the strobe is seen; the
	// host opens its sampling window later than that.
	always_ff @(posedge clk) begin
		if (rst) begin
			bus.ready <= 1'b0;
		end else begin
			bus.ready <= !busy;
		end
	end
	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	// Data stays until the strobe drops, which covers the host capture
	always_ff @(posedge clk) begin
		if (rst) begin
			bus.dev_doe_n <= 1'b1;
		end else begin
			bus.dev_doe_n <= !is_read;
		end
	end
	// Read word is loaded once, at the end of the latency count
	always_ff @(posedge clk) begin
		if (rst) begin
			bus.dev_dout <= '0;
		end else if (finish) begin
			bus.dev_dout <= {16'h0000, read_steer(rd_half, bus.addr[0])};
		end
	end
	// ---------------------------------------------------------------
	// Strap report
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_active_high <= VLP_STRAP_RESET;
		end else begin
			hold_active_high <= pol_q;
		end
	end
endmodule : vlp_device

// ===== verilog/vlp_host.sv
// Host end: static-memory controller issuing variable-latency IO cycles
`timescale 1ns/100ps
module vlp_host
	import vlp_pkg::*;
#(
	parameter int FIRST_ACCESS_DELAY = VLP_FIRST_ACCESS_DELAY,
	parameter int COMMAND_PRECHARGE = VLP_COMMAND_PRECHARGE
) (
	input wire logic clk,
	input wire logic rst,
	vlp_bus_if.host bus,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_burst,
	input wire logic [1:0] req_select,
	input wire logic [VLP_ADDR_W-1:0] req_addr,
	input wire logic [3:0] req_lanes,
	input wire logic [VLP_DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [VLP_DATA_W-1:0] rsp_rdata
);
	localparam int HALF_W = 8;
	localparam int STROBE_HALVES = 2 * (FIRST_ACCESS_DELAY + 1);
	localparam int SAMPLE_START = STROBE_HALVES - 2 * VLP_READY_EARLY;
	localparam int PRECH_HALVES = 2 * (COMMAND_PRECHARGE + 1);
	vlp_host_e state_q;
	logic half_q;
	logic [HALF_W-1:0] cnt_q;
	logic [1:0] good_q;
	logic write_q;
	logic [VLP_SEL_W-1:0] sel_q;
	// ---------------------------------------------------------------
	// Half-cycle tick: odd ticks are rising memory edges
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			half_q <= 1'b0;
		end else begin
			half_q <= !half_q;
		end
	end
	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= VLP_H_IDLE;
			cnt_q <= '0;
			good_q <= '0;
			write_q <= 1'b0;
			sel_q <= VLP_SEL_IDLE;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			bus.addr <= '0;
			bus.host_select_low <= VLP_SEL_IDLE;
			bus.lane_strobe_low <= VLP_LANE_IDLE;
			bus.read_strobe_low <= 1'b1;
			bus.write_strobe_low <= 1'b1;
			bus.host_dout <= '0;
			bus.host_doe_n <= 1'b1;
		end else begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			cnt_q <= cnt_q + 1'b1;
			case (state_q)
				VLP_H_IDLE: begin
					if (req_valid && !half_q && !req_ready) begin
						req_ready <= 1'b1;
						write_q <= req_write;
						// Only selects 3..5 may carry ready-stretched devices; this decode drives selects 0..2
						sel_q <= ~(3'h1 << req_select);
						bus.host_select_low <= ~(3'h1 << req_select);
						bus.addr <= req_addr;
						bus.lane_strobe_low <= req_lanes;
						bus.host_dout <= req_wdata;
						bus.host_doe_n <= !req_write;
						cnt_q <= '0;
						state_q <= VLP_H_SETUP;
					end
				end
				VLP_H_SETUP: begin
					if (cnt_q == HALF_W'(2 * VLP_SELECT_TO_READ - 1)) begin
						bus.read_strobe_low <= write_q;
						bus.write_strobe_low <= !write_q;
						cnt_q <= '0;
						good_q <= '0;
						state_q <= VLP_H_STROBE;
					end
				end
				VLP_H_STROBE: begin
					// Sampling opens two cycles before the minimum width ends
					if (cnt_q >= HALF_W'(SAMPLE_START - 1)) begin
						if (!bus.ready) begin
							good_q <= '0;
						end else if (good_q == 2'(VLP_READY_SAMPLES - 1)) begin
							if (half_q) begin
								state_q <= VLP_H_CAPTURE;
							end
						end else if (good_q != 2'h0 || half_q) begin
							good_q <= good_q + 2'h1;
						end
					end
				end
				VLP_H_CAPTURE: begin
					if (!write_q) begin
						rsp_rdata <= bus.data;
					end
					rsp_valid <= 1'b1;
					bus.read_strobe_low <= 1'b1;
					bus.write_strobe_low <= 1'b1;
					cnt_q <= '0;
					state_q <= VLP_H_PRECH;
				end
				VLP_H_PRECH: begin
					if (cnt_q == HALF_W'(PRECH_HALVES - 1) && req_valid && req_burst
						&& !req_ready) begin
						req_ready <= 1'b1;
						write_q <= req_write;
						bus.addr <= req_addr;
						bus.lane_strobe_low <= req_lanes;
						bus.host_dout <= req_wdata;
						bus.host_doe_n <= !req_write;
						bus.read_strobe_low <= req_write;
						bus.write_strobe_low <= !req_write;
						cnt_q <= '0;
						good_q <= '0;
						state_q <= VLP_H_STROBE;
					end else if (cnt_q >= HALF_W'(2 * VLP_SELECT_HOLD - 1)
						&& !(req_valid && req_burst)) begin
						bus.host_select_low <= VLP_SEL_IDLE;
						bus.lane_strobe_low <= VLP_LANE_IDLE;
						bus.host_doe_n <= 1'b1;
						sel_q <= VLP_SEL_IDLE;
						state_q <= VLP_H_IDLE;
					end
				end
				default: begin
					state_q <= VLP_H_IDLE;
				end
			endcase
		end
	end
endmodule : vlp_host

// ===== verilog/vlp_pkg.sv
// Shared constants and types for the variable-latency IO slave port
package vlp_pkg;
	// ---------------------------------------------------------------
	// Bus geometry
	// ---------------------------------------------------------------
	localparam int VLP_ADDR_W = 26;
	localparam int VLP_DATA_W = 32;
	localparam int VLP_LANES = 4;
	localparam int VLP_SEL_W = 3;
	localparam logic [2:0] VLP_SEL_IDLE = 3'h7;
	localparam logic [3:0] VLP_LANE_IDLE = 4'hF;
	// ---------------------------------------------------------------
	// Timing in memory cycles (one memory cycle = two half-cycle ticks); VLP_DEVICE_LATENCY and VLP_READY_SAMPLES count ticks
	// ---------------------------------------------------------------
	localparam int VLP_HALF_DIV = 2;
	localparam int VLP_SELECT_TO_READ = 2;
	localparam int VLP_READY_EARLY = 2;
	localparam int VLP_READY_SAMPLES = 3;
	localparam int VLP_SELECT_HOLD = 1;
	localparam int VLP_FIRST_ACCESS_DELAY = 2;
	localparam int VLP_COMMAND_PRECHARGE = 0;
	localparam int VLP_DEVICE_LATENCY = 5;
	localparam logic VLP_STRAP_RESET = 1'b0;
	// ---------------------------------------------------------------
	// Host sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		VLP_H_IDLE = 3'b000,
		VLP_H_SETUP = 3'b001,
		VLP_H_STROBE = 3'b010,
		VLP_H_CAPTURE = 3'b011,
		VLP_H_PRECH = 3'b100,
		VLP_H_HOLD = 3'b101
	} vlp_host_e;
	// Device states
	typedef enum logic [1:0] {
		VLP_D_IDLE = 2'b00,
		VLP_D_BUSY = 2'b01,
		VLP_D_DONE = 2'b10
	} vlp_dev_e;
	// Byte count from the low-active lane strobes
	function automatic logic [2:0] vlp_lane_count(input logic [3:0] lanes_low);
		vlp_lane_count = 3'(!lanes_low[0]) + 3'(!lanes_low[1]) + 3'(!lanes_low[2])
			+ 3'(!lanes_low[3]);
	endfunction : vlp_lane_count
endpackage : vlp_pkg
